// ===== mdio_pkg.sv
// Purpose: shared constants and types of the management link, device and station
// Assumes: pclk of 25 MHz on both ends
// Notes: register offsets are device-4 word addresses carried in the address/data field
package mdio_pkg;
	// frame layout
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [4:0] HDR_LAST = 5'h0D;
	localparam logic [4:0] TA_LAST = 5'h01;
	localparam logic [4:0] DATA_LAST = 5'h0F;
	localparam logic [31:0] PREAMBLE_WORD = 32'hFFFFFFFF;
	localparam logic [1:0] ST_INDIRECT = 2'h0;
	localparam logic [1:0] ST_LEGACY = 2'h1;
	localparam logic [1:0] TA_WRITE = 2'h2;
	localparam logic [4:0] XS_DEVICE_TYPE = 5'h04;
	typedef enum logic [1:0] {OP_ADDR = 2'b00, OP_WRITE = 2'b01, OP_READ_INC = 2'b10, OP_READ = 2'b11} mdio_op_e;
	typedef enum logic [1:0] {FR_PRE = 2'b00, FR_HDR = 2'b01, FR_TA = 2'b10, FR_DATA = 2'b11} frame_e;
	typedef enum logic [0:0] {SQ_IDLE = 1'b0, SQ_RUN = 1'b1} seq_e;
	// device-4 register space
	localparam logic [15:0] REG_CTRL1 = 16'h0000;
	localparam logic [15:0] REG_STAT1 = 16'h0001;
	localparam logic [15:0] REG_IDH = 16'h0002;
	localparam logic [15:0] REG_IDL = 16'h0003;
	localparam logic [15:0] REG_ABILITY = 16'h0004;
	localparam logic [15:0] REG_STAT2 = 16'h0005;
	localparam logic [15:0] REG_PRESENT = 16'h0008;
	localparam logic [15:0] REG_LANE = 16'h0018;
	localparam logic [15:0] REG_VCTRL = 16'h8002;
	localparam logic [15:0] REG_VSTAT = 16'h8003;
	localparam logic [15:0] REG_VCAP0 = 16'h8004;
	localparam logic [15:0] REG_VCAP1 = 16'h8005;
	localparam logic [15:0] CORE_WIN_MASK = 16'hF000;
	localparam logic [15:0] CORE_WIN = 16'h9000;
	localparam logic [7:0] CORE_PAGE = 8'h30;
	localparam logic [15:0] ABILITY_VALUE = 16'h0001;
	localparam logic [15:0] STAT2_VALUE = 16'h0010;
	localparam logic [15:0] PRESENT_VALUE = 16'h8000;
	localparam int CTL_RESET_BIT = 15;
	localparam int CTL_LOOP_BIT = 14;
	localparam int CTL_POWER_BIT = 11;
	localparam int STAT1_LINK_BIT = 2;
	localparam int STAT1_LPABLE_BIT = 1;
	localparam int LANE_ALIGN_BIT = 12;
	localparam int VCTL_AUTO_BIT = 15;
	// embedded transceiver core registers and values
	localparam logic [19:0] CORE_WORD_ALIGN = 20'h30910;
	localparam logic [19:0] CORE_LANE_ALIGN = 20'h30920;
	localparam logic [19:0] CORE_LANE_STATE = 20'h30904;
	localparam logic [19:0] CORE_WA_STAT = 20'h30905;
	localparam logic [19:0] CORE_OOS = 20'h30914;
	localparam logic [19:0] CORE_SOFT_RST = 20'h30105;
	localparam logic [19:0] CORE_LOOP_A = 20'h30801;
	localparam logic [19:0] CORE_LOOP_B = 20'h30901;
	localparam logic [7:0] D_WA_OFF = 8'h00;
	localparam logic [7:0] D_WA_ON = 8'h0F;
	localparam logic [7:0] D_WA_ALL = 8'hFF;
	localparam logic [7:0] D_LA_XAUI = 8'h01;
	localparam logic [7:0] D_LA_RESYNC = 8'h03;
	localparam logic [7:0] D_RST_ON = 8'h64;
	localparam logic [7:0] D_RST_OFF = 8'h44;
	localparam logic [7:0] D_LOOP_ON = 8'h0F;
	localparam logic [7:0] D_LOOP_OFF = 8'h00;
	localparam logic [4:0] SEQ_INIT_FIRST = 5'h00;
	localparam logic [4:0] SEQ_INIT_LAST = 5'h0A;
	localparam logic [4:0] SEQ_RESYNC_FIRST = 5'h0B;
	localparam logic [4:0] SEQ_RESYNC_LAST = 5'h0E;
	localparam logic [4:0] SEQ_LOOP_FIRST = 5'h0F;
	localparam logic [4:0] SEQ_LOOP_LAST = 5'h10;
	typedef struct packed {
		logic we;
		logic [19:0] addr;
		logic [7:0] data;
	} core_op_s;
	// station registers (byte addresses on APB)
	localparam logic [7:0] STN_CMD = 8'h00;
	localparam logic [7:0] STN_STAT = 8'h04;
	localparam logic [7:0] STN_RDATA = 8'h08;
	localparam logic [7:0] STN_DIV = 8'h0C;
	localparam int CMD_OP_LSB = 16;
	localparam int CMD_PRT_LSB = 18;
	localparam int CMD_DEV_LSB = 23;
	localparam int CMD_LEGACY_BIT = 28;
	localparam logic [6:0] STN_TA_FIRST = 7'h2E;
	localparam logic [6:0] STN_DATA_FIRST = 7'h30;
	localparam logic [6:0] STN_FRAME_LAST = 7'h3F;
	// management clock limit
	localparam int PCLK_FREQ_KHZ = 25000;
	localparam int MDC_MAX_FREQ_KHZ = 2500;
	localparam logic [7:0] MDC_HALF_MIN = 8'((PCLK_FREQ_KHZ + 2 * MDC_MAX_FREQ_KHZ - 1) / (2 * MDC_MAX_FREQ_KHZ));
endpackage

// ===== mdio_link_if.sv
// Purpose: the two-wire management link between station and device
// Assumes: the data line has a pull-up, so a released line reads 1
// Notes: each end drives its own copy; the level is worked out here
`timescale 1ns/1ps
`default_nettype none
interface mdio_link_if;
	logic mdc;
	logic stn_o;
	logic stn_oe_n;
	logic dev_o;
	logic dev_oe_n;
	logic mdio;
	assign mdio = (stn_oe_n | stn_o) & (dev_oe_n | dev_o);
	modport station (output mdc, output stn_o, output stn_oe_n, input mdio);
	modport device (input mdc, input mdio, output dev_o, output dev_oe_n);
endinterface
`default_nettype wire

// ===== mdio_device.sv
// Purpose: management slave for device 4 plus lane realignment and config-tail sequencer
// Assumes: lane status and the core port run on pclk; mdc, mdio and pwrup_init_en are asynchronous
// Notes: a core read must be answered within two mdc periods or stale data goes out
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - auto realignment only while vendor enable set
// - word align: write 0F then FF
// - lane align: write 01 then 03
// - read lane-state, aligner, out-of-sync bytes
// - core soft reset: 64, two reads, 44
// - station makes mdc, at most 2.5MHz
// - 64-bit frame, 32 preamble ones
// - start field 00, then operation code
// - port address msb first, then device type
// - legacy start 01 frames get no response
// - turnaround bit values are ignored
// - 16-bit address/data field, msb first
// - address frame stores address; others carry data
// - read-increment advances stored address by one
// - answer device 4, standard registers
// - vendor range and 9xxx core window
// - device type zero never answered
// - loopback bit programs core loop registers
// - vendor control and status registers exist
module mdio_device
	import mdio_pkg::*;
#(
	parameter logic [4:0] PORT_ADDR = 5'h01,
	parameter logic [15:0] IDENT_HIGH = 16'h1234, // arbitrary value
	parameter logic [15:0] IDENT_LOW = 16'h5678 // arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	mdio_link_if.device link,
	input wire logic pwrup_init_en,
	input wire logic [3:0] lane_sync,
	input wire logic lane_aligned,
	output logic core_req,
	output logic core_we,
	output logic [19:0] core_addr,
	output logic [7:0] core_wdata,
	input wire logic [7:0] core_rdata,
	input wire logic core_ack,
	output logic sublayer_reset,
	output logic loopback_en,
	output logic normal_power
);
	typedef struct packed {
		logic mdc_s1, mdc_s2, mdc_s3, dio_s1, dio_s2, init_s1, init_s2;
		frame_e fr;
		logic [5:0] ones;
		logic [4:0] cnt;
		logic [12:0] hdr;
		logic [1:0] op;
		logic [15:0] sh, addr, rd_word;
		logic dio_o, dio_oe_n;
		logic ctl_lb, ctl_pwr, auto_en, xs_rst;
		logic cpend, cp_we;
		logic [11:0] cp_addr;
		logic [7:0] cp_data;
		logic cbusy, csrc, core_req, core_we;
		logic [19:0] core_addr;
		logic [7:0] core_wdata;
		seq_e sq;
		logic [4:0] sidx, send;
		logic boot_taken, init_done, rs_pend, lb_pend, sync_prev, init_v1, init_v2;
		logic [7:0] cap0, cap1, cap2;
	} dev_state_s;

	dev_state_s s_reg;
	dev_state_s s_next;
	logic rise;
	logic all_sync;
	logic [13:0] hdr_full;
	logic [15:0] word_in;
	core_op_s step;

	function automatic logic core_window(input logic [15:0] a);
		return (a & CORE_WIN_MASK) == CORE_WIN;
	endfunction

	function automatic core_op_s seq_step(input logic [4:0] i, input logic lb);
		core_op_s c;
		c = '{we: 1'b1, addr: CORE_WORD_ALIGN, data: D_WA_ON};
		case (i)
			5'h00: c = '{we: 1'b0, addr: CORE_LANE_STATE, data: 8'h00};
			5'h01: c = '{we: 1'b0, addr: CORE_WA_STAT, data: 8'h00};
			5'h02: c = '{we: 1'b0, addr: CORE_OOS, data: 8'h00};
			5'h03: c = '{we: 1'b1, addr: CORE_SOFT_RST, data: D_RST_ON};
			5'h04, 5'h05: c = '{we: 1'b0, addr: CORE_SOFT_RST, data: 8'h00};
			5'h06: c = '{we: 1'b1, addr: CORE_SOFT_RST, data: D_RST_OFF};
			5'h07: c = '{we: 1'b1, addr: CORE_WORD_ALIGN, data: D_WA_OFF};
			5'h08: c = '{we: 1'b1, addr: CORE_WORD_ALIGN, data: D_WA_ON};
			5'h09: c = '{we: 1'b1, addr: CORE_LANE_ALIGN, data: D_LA_XAUI};
			5'h0A: c = '{we: 1'b1, addr: CORE_LANE_ALIGN, data: D_LA_RESYNC};
			5'h0B: c = '{we: 1'b1, addr: CORE_WORD_ALIGN, data: D_WA_ON};
			5'h0C: c = '{we: 1'b1, addr: CORE_WORD_ALIGN, data: D_WA_ALL};
			5'h0D: c = '{we: 1'b1, addr: CORE_LANE_ALIGN, data: D_LA_XAUI};
			5'h0E: c = '{we: 1'b1, addr: CORE_LANE_ALIGN, data: D_LA_RESYNC};
			5'h0F: c = '{we: 1'b1, addr: CORE_LOOP_A, data: lb ? D_LOOP_ON : D_LOOP_OFF};
			default: c = '{we: 1'b1, addr: CORE_LOOP_B, data: lb ? D_LOOP_ON : D_LOOP_OFF};
		endcase
		return c;
	endfunction

	function automatic logic [15:0] local_read(input logic [15:0] a, input dev_state_s st,
			input logic [3:0] ls, input logic al);
		logic [15:0] v;
		v = '0;
		// the reset bit is never stored, so it always reads back 0
		if (a == REG_CTRL1) begin
			v[CTL_LOOP_BIT] = st.ctl_lb;
			v[CTL_POWER_BIT] = st.ctl_pwr;
		end else if (a == REG_STAT1) begin
			v[STAT1_LINK_BIT] = (&ls) & al;
			v[STAT1_LPABLE_BIT] = 1'b1;
		end else if (a == REG_IDH) begin
			v = IDENT_HIGH;
		end else if (a == REG_IDL) begin
			v = IDENT_LOW;
		end else if (a == REG_ABILITY) begin
			v = ABILITY_VALUE;
		end else if (a == REG_STAT2) begin
			v = STAT2_VALUE;
		end else if (a == REG_PRESENT) begin
			v = PRESENT_VALUE;
		end else if (a == REG_LANE) begin
			v[3:0] = ls;
			v[LANE_ALIGN_BIT] = al;
		end else if (a == REG_VCTRL) begin
			v[VCTL_AUTO_BIT] = st.auto_en;
		end else if (a == REG_VSTAT) begin
			v = {13'h0000, st.rs_pend, st.init_done, st.sq == SQ_RUN};
		end else if (a == REG_VCAP0) begin
			v = {st.cap1, st.cap0};
		end else if (a == REG_VCAP1) begin
			v = {8'h00, st.cap2};
		end
		return v;
	endfunction

	always_comb begin
		s_next = s_reg;
		s_next.xs_rst = 1'b0;
		s_next.mdc_s1 = link.mdc;
		s_next.mdc_s2 = s_reg.mdc_s1;
		s_next.mdc_s3 = s_reg.mdc_s2;
		s_next.dio_s1 = link.mdio;
		s_next.dio_s2 = s_reg.dio_s1;
		s_next.init_s1 = pwrup_init_en;
		s_next.init_s2 = s_reg.init_s1;
		// validity marks travel beside the synchroniser so its reset value is never taken as the pin
		s_next.init_v1 = 1'b1;
		s_next.init_v2 = s_reg.init_v1;
		rise = s_reg.mdc_s2 & ~s_reg.mdc_s3;
		all_sync = &lane_sync;
		hdr_full = {s_reg.hdr, s_reg.dio_s2};
		word_in = {s_reg.sh[14:0], s_reg.dio_s2};
		step = seq_step(s_reg.sidx, s_reg.ctl_lb);

		// core port: one access at a time, a pending management access goes first
		if (!s_reg.cbusy) begin
			if (s_reg.cpend) begin
				s_next.cbusy = 1'b1;
				s_next.csrc = 1'b0;
				s_next.core_req = 1'b1;
				s_next.core_we = s_reg.cp_we;
				s_next.core_addr = {CORE_PAGE, s_reg.cp_addr};
				s_next.core_wdata = s_reg.cp_data;
				s_next.cpend = 1'b0;
			end else if (s_reg.sq == SQ_RUN) begin
				s_next.cbusy = 1'b1;
				s_next.csrc = 1'b1;
				s_next.core_req = 1'b1;
				s_next.core_we = step.we;
				s_next.core_addr = step.addr;
				s_next.core_wdata = step.data;
			end
		end else if (core_ack) begin
			s_next.cbusy = 1'b0;
			s_next.core_req = 1'b0;
			if (!s_reg.csrc) begin
				if (!s_reg.core_we) begin
					s_next.rd_word = {8'h00, core_rdata};
				end
			end else begin
				if (s_reg.sidx == 5'h00) s_next.cap0 = core_rdata;
				if (s_reg.sidx == 5'h01) s_next.cap1 = core_rdata;
				if (s_reg.sidx == 5'h02) s_next.cap2 = core_rdata;
				if (s_reg.sidx == s_reg.send) begin
					s_next.sq = SQ_IDLE;
					if (s_reg.send == SEQ_INIT_LAST) s_next.init_done = 1'b1;
				end else begin
					s_next.sidx = 5'(s_reg.sidx + 5'h01);
				end
			end
		end

		// sequencer launch: boot tail, then realignment, then loopback programming
		if (s_reg.sq == SQ_IDLE && !s_reg.cbusy) begin
			if (!s_reg.boot_taken) begin
				if (s_reg.init_v2) begin
					s_next.boot_taken = 1'b1;
					if (s_reg.init_s2) begin
						s_next.sq = SQ_RUN;
						s_next.sidx = SEQ_INIT_FIRST;
						s_next.send = SEQ_INIT_LAST;
						s_next.init_done = 1'b0;
					end
				end
			end else if (s_reg.rs_pend) begin
				s_next.rs_pend = 1'b0;
				s_next.sq = SQ_RUN;
				s_next.sidx = SEQ_RESYNC_FIRST;
				s_next.send = SEQ_RESYNC_LAST;
			end else if (s_reg.lb_pend) begin
				s_next.lb_pend = 1'b0;
				s_next.sq = SQ_RUN;
				s_next.sidx = SEQ_LOOP_FIRST;
				s_next.send = SEQ_LOOP_LAST;
			end
		end
		// loss of sync is caught on the falling edge of all-lanes-synced; set beats the clear above
		s_next.sync_prev = all_sync;
		if (!s_reg.auto_en) s_next.rs_pend = 1'b0;
		if (s_reg.auto_en && s_reg.sync_prev && !all_sync) s_next.rs_pend = 1'b1;

		// frame receiver, advanced on each rising mdc edge seen through the synchroniser
		if (rise) begin
			case (s_reg.fr)
				FR_PRE: begin
					if (s_reg.dio_s2) begin
						if (s_reg.ones != PREAMBLE_LEN) s_next.ones = 6'(s_reg.ones + 6'h01);
					end else begin
						s_next.ones = '0;
						if (s_reg.ones == PREAMBLE_LEN) begin
							s_next.fr = FR_HDR;
							s_next.hdr = '0;
							s_next.cnt = 5'h01;
						end
					end
				end
				FR_HDR: begin
					s_next.hdr = hdr_full[12:0];
					s_next.cnt = 5'(s_reg.cnt + 5'h01);
					if (s_reg.cnt == HDR_LAST) begin
						s_next.cnt = '0;
						s_next.op = hdr_full[11:10];
						// legacy start, other ports and device types (zero included) are dropped
						if (hdr_full[13:12] != ST_INDIRECT || hdr_full[9:5] != PORT_ADDR
								|| hdr_full[4:0] != XS_DEVICE_TYPE) begin
							s_next.fr = FR_PRE;
						end else begin
							s_next.fr = FR_TA;
							if (hdr_full[11]) begin
								if (core_window(s_reg.addr)) begin
									s_next.cpend = 1'b1;
									s_next.cp_we = 1'b0;
									s_next.cp_addr = s_reg.addr[11:0];
								end else begin
									s_next.rd_word = local_read(s_reg.addr, s_reg, lane_sync, lane_aligned);
								end
							end
						end
					end
				end
				FR_TA: begin
					s_next.cnt = 5'(s_reg.cnt + 5'h01);
					if (s_reg.cnt == TA_LAST) begin
						s_next.fr = FR_DATA;
						s_next.cnt = '0;
						s_next.sh = s_reg.rd_word;
						if (s_reg.op[1]) begin
							s_next.dio_o = s_reg.rd_word[15];
							s_next.dio_oe_n = 1'b0;
						end
					end
				end
				default: begin
					s_next.sh = word_in;
					s_next.cnt = 5'(s_reg.cnt + 5'h01);
					if (s_reg.op[1]) s_next.dio_o = s_reg.sh[14];
					if (s_reg.cnt == DATA_LAST) begin
						s_next.fr = FR_PRE;
						s_next.cnt = '0;
						s_next.dio_oe_n = 1'b1;
						case (mdio_op_e'(s_reg.op))
							OP_ADDR: s_next.addr = word_in;
							OP_READ_INC: s_next.addr = 16'(s_reg.addr + 16'h0001);
							OP_WRITE: begin
								if (s_reg.addr == REG_CTRL1) begin
									s_next.ctl_lb = word_in[CTL_LOOP_BIT];
									s_next.ctl_pwr = word_in[CTL_POWER_BIT];
									s_next.lb_pend = 1'b1;
									if (word_in[CTL_RESET_BIT]) begin
										s_next.xs_rst = 1'b1;
										s_next.ctl_lb = 1'b0;
										s_next.ctl_pwr = 1'b1;
										s_next.boot_taken = 1'b0;
									end
								end else if (s_reg.addr == REG_VCTRL) begin
									s_next.auto_en = word_in[VCTL_AUTO_BIT];
								end else if (core_window(s_reg.addr)) begin
									s_next.cpend = 1'b1;
									s_next.cp_we = 1'b1;
									s_next.cp_addr = s_reg.addr[11:0];
									s_next.cp_data = word_in[7:0];
								end
							end
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.dio_oe_n <= 1'b1;
			s_reg.ctl_pwr <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.dev_o = s_reg.dio_o;
	assign link.dev_oe_n = s_reg.dio_oe_n;
	assign core_req = s_reg.core_req;
	assign core_we = s_reg.core_we;
	assign core_addr = s_reg.core_addr;
	assign core_wdata = s_reg.core_wdata;
	assign sublayer_reset = s_reg.xs_rst;
	assign loopback_en = s_reg.ctl_lb;
	assign normal_power = s_reg.ctl_pwr;
endmodule
`default_nettype wire

// ===== mdio_station.sv
// Purpose: management station; software launches frames through APB registers
// Assumes: APB3 slave with one wait state on every access
// Notes: a command written while a frame runs is dropped
`timescale 1ns/1ps
`default_nettype none
module mdio_station
	import mdio_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	mdio_link_if.station link
);
	typedef struct packed {
		logic dio_s1, dio_s2, busy, rd, mdc, o, oe_n, pready, pslverr;
		logic [6:0] bitn;
		logic [7:0] cnt, half;
		logic [63:0] sh;
		logic [15:0] rdata;
		logic [31:0] prdata;
	} stn_state_s;

	stn_state_s s_reg;
	stn_state_s s_next;
	logic acc;
	logic [1:0] st_sel;

	always_comb begin
		s_next = s_reg;
		s_next.dio_s1 = link.mdio;
		s_next.dio_s2 = s_reg.dio_s1;
		s_next.pready = 1'b0;
		acc = psel & penable;
		st_sel = pwdata[CMD_LEGACY_BIT] ? ST_LEGACY : ST_INDIRECT;
		// first access cycle prepares the answer, the second completes it
		if (acc && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.pslverr = 1'b0;
			s_next.prdata = '0;
			if (paddr == STN_CMD) begin
				s_next.prdata = '0;
			end else if (paddr == STN_STAT) begin
				s_next.prdata = {31'h00000000, s_reg.busy};
			end else if (paddr == STN_RDATA) begin
				s_next.prdata = {16'h0000, s_reg.rdata};
			end else if (paddr == STN_DIV) begin
				s_next.prdata = {24'h000000, s_reg.half};
			end else begin
				s_next.pslverr = 1'b1;
			end
		end
		if (acc && s_reg.pready && pwrite) begin
			if (paddr == STN_CMD && !s_reg.busy) begin
				s_next.busy = 1'b1;
				s_next.rd = pwdata[CMD_OP_LSB + 1];
				s_next.bitn = '0;
				s_next.cnt = '0;
				s_next.mdc = 1'b0;
				s_next.sh = {PREAMBLE_WORD, st_sel, pwdata[CMD_OP_LSB +: 2],
					pwdata[CMD_PRT_LSB +: 5], pwdata[CMD_DEV_LSB +: 5], TA_WRITE, pwdata[15:0]};
				s_next.o = 1'b1;
				s_next.oe_n = 1'b0;
			end else if (paddr == STN_DIV) begin
				// clamp keeps mdc at or below its ceiling whatever software writes
				s_next.half = (pwdata[7:0] < MDC_HALF_MIN) ? MDC_HALF_MIN : pwdata[7:0];
			end
		end
		// clock divider: data changes after the falling edge, samples on the rising
		if (s_reg.busy) begin
			s_next.cnt = 8'(s_reg.cnt + 8'h01);
			if (s_reg.cnt == 8'(s_reg.half - 8'h01)) begin
				s_next.cnt = '0;
				if (!s_reg.mdc) begin
					s_next.mdc = 1'b1;
					if (s_reg.rd && s_reg.bitn >= STN_DATA_FIRST) s_next.rdata = {s_reg.rdata[14:0], s_reg.dio_s2};
				end else begin
					s_next.mdc = 1'b0;
					if (s_reg.bitn == STN_FRAME_LAST) begin
						s_next.busy = 1'b0;
						s_next.oe_n = 1'b1;
					end else begin
						s_next.bitn = 7'(s_reg.bitn + 7'h01);
						s_next.sh = {s_reg.sh[62:0], 1'b0};
						s_next.o = s_reg.sh[62];
						s_next.oe_n = s_reg.rd && (7'(s_reg.bitn + 7'h01) >= STN_TA_FIRST);
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.oe_n <= 1'b1;
			s_reg.half <= MDC_HALF_MIN;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign link.mdc = s_reg.mdc;
	assign link.stn_o = s_reg.o;
	assign link.stn_oe_n = s_reg.oe_n;
endmodule
`default_nettype wire

// ===== mdio_link_props.sv
// Purpose: timing and ownership checks on the management link
// Assumes: mdc half period of 5 pclk, frames separated by more than 8 idle pclk
// Notes: bitn counts rising mdc edges inside a frame; it clears after a long low mdc
`timescale 1ns/1ps
`default_nettype none
module mdio_link_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mdc,
	input wire logic stn_o,
	input wire logic stn_oe_n,
	input wire logic dev_o,
	input wire logic dev_oe_n
);
	logic mdc_q;
	logic [6:0] bitn;
	logic [3:0] idle;
	logic [7:0] dcnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mdc_q <= 1'b0;
			bitn <= '0;
			idle <= '0;
			dcnt <= '0;
		end else begin
			mdc_q <= mdc;
			idle <= mdc ? 4'h0 : ((idle == 4'hF) ? idle : idle + 4'h1);
			if (mdc && !mdc_q)
				bitn <= bitn + 7'h01;
			else if (idle == 4'h8)
				bitn <= '0;
			dcnt <= dev_oe_n ? 8'h00 : ((dcnt == 8'hFF) ? dcnt : dcnt + 8'h01);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_high_half;
		mdc [*5];
	endsequence
	sequence s_low_half;
		!mdc [*5];
	endsequence
	chk_no_contention: assert property (!stn_oe_n |-> dev_oe_n)
		else $error("both ends drive the data line");
	chk_dev_window: assert property (!dev_oe_n |-> bitn >= 7'd48)
		else $error("device drives outside the read data field");
	chk_mdc_high_half: assert property ($rose(mdc) |-> s_high_half)
		else $error("mdc high phase too short");
	chk_mdc_low_half: assert property (($fell(mdc) && bitn < 7'd64) |-> s_low_half)
		else $error("mdc low phase too short");
	chk_preamble_ones: assert property ((!stn_oe_n && bitn < 7'd32) |-> stn_o)
		else $error("preamble bit not one");
	chk_frame_len: assert property ($rose(mdc) |-> bitn < 7'd64)
		else $error("more than 64 clock edges in a frame");
	chk_dev_word_len: assert property ($rose(dev_oe_n) |-> (dcnt >= 8'd155 && dcnt <= 8'd165))
		else $error("read data field not 16 bit periods");
	chk_dev_shift_rise: assert property ((!dev_oe_n && $past(!dev_oe_n) && $changed(dev_o)) |-> (mdc || $past(mdc)))
		else $error("device data changed in low mdc phase");
	chk_stn_shift_fall: assert property ((!stn_oe_n && $past(!stn_oe_n) && $changed(stn_o)) |-> !mdc)
		else $error("station data changed in high mdc phase");
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: station and device joined over one link, driven through APB
// Assumes: core port answered here after one cycle with data addr ^ A5
// Notes: core accesses are logged so sequencer steps can be compared in order
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import mdio_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, core_req, core_we, core_ack = 1'b0, sublayer_reset, loopback_en, normal_power;
	logic [3:0] lane_sync = 4'hF;
	logic [19:0] core_addr;
	logic [7:0] core_wdata, core_rdata = 8'h00;
	core_op_s log[$];
	int n_fail = 0, total_checks = 0, rst_cnt = 0, i;
	logic [15:0] rows [10][2] = '{'{REG_IDH, 16'h1234}, '{REG_IDL, 16'h5678}, '{REG_ABILITY, ABILITY_VALUE},
		'{REG_STAT2, STAT2_VALUE}, '{REG_PRESENT, PRESENT_VALUE}, '{REG_CTRL1, 16'h0800}, '{REG_LANE, 16'h100F},
		'{REG_STAT1, 16'h0006}, '{16'h0010, 16'h0000}, '{16'h9904, {8'h00, 8'h04 ^ 8'hA5}}};
	core_op_s tail [15] = '{'{1'b0, CORE_LANE_STATE, 8'h00}, '{1'b0, CORE_WA_STAT, 8'h00}, '{1'b0, CORE_OOS, 8'h00},
		'{1'b1, CORE_SOFT_RST, D_RST_ON}, '{1'b0, CORE_SOFT_RST, 8'h00}, '{1'b0, CORE_SOFT_RST, 8'h00},
		'{1'b1, CORE_SOFT_RST, D_RST_OFF}, '{1'b1, CORE_WORD_ALIGN, D_WA_OFF}, '{1'b1, CORE_WORD_ALIGN, D_WA_ON},
		'{1'b1, CORE_LANE_ALIGN, D_LA_XAUI}, '{1'b1, CORE_LANE_ALIGN, D_LA_RESYNC}, '{1'b1, CORE_WORD_ALIGN, D_WA_ON},
		'{1'b1, CORE_WORD_ALIGN, D_WA_ALL}, '{1'b1, CORE_LANE_ALIGN, D_LA_XAUI}, '{1'b1, CORE_LANE_ALIGN, D_LA_RESYNC}};
	mdio_link_if link();
	mdio_station mdio_station_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	mdio_device #(.PORT_ADDR(5'h01), .IDENT_HIGH(16'h1234), .IDENT_LOW(16'h5678)) mdio_device_i (.pclk(pclk),
		.presetn(presetn), .link(link), .pwrup_init_en(1'b1), .lane_sync(lane_sync), .lane_aligned(1'b1),
		.core_req(core_req), .core_we(core_we), .core_addr(core_addr), .core_wdata(core_wdata),
		.core_rdata(core_rdata), .core_ack(core_ack), .sublayer_reset(sublayer_reset),
		.loopback_en(loopback_en), .normal_power(normal_power));
	mdio_link_props mdio_link_props_i (.pclk(pclk), .presetn(presetn), .mdc(link.mdc), .stn_o(link.stn_o),
		.stn_oe_n(link.stn_oe_n), .dev_o(link.dev_o), .dev_oe_n(link.dev_oe_n));
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		core_ack <= core_req && !core_ack;
		core_rdata <= core_addr[7:0] ^ 8'hA5;
		rst_cnt <= rst_cnt + int'(sublayer_reset === 1'b1);
		if (core_req && core_ack)
			log.push_back('{core_we, core_addr, core_we ? core_wdata : 8'h00});
	end
	task automatic stop_test();
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50 && pready !== 1'b1; k++)
			@(posedge pclk);
		if (k == 50) begin
			n_fail++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic frame(input logic [1:0] op, input logic [15:0] d, input logic [4:0] dv = XS_DEVICE_TYPE,
		input logic [4:0] pt = 5'h01, input logic lg = 1'b0);
		int k;
		apb(1'b1, STN_CMD, {3'h0, lg, dv, pt, op, d});
		for (k = 0; k < 300; k++) begin
			apb(1'b0, STN_STAT, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		if (k == 300) begin
			n_fail++;
			stop_test();
		end
		apb(1'b0, STN_RDATA, 32'h0);
	endtask
	task automatic wait_log(input int n);
		for (int k = 0; k < 3000 && log.size() < n; k++)
			@(posedge pclk);
		chk(32'(log.size()), 32'(n));
		if (log.size() < n)
			stop_test();
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		chk(32'({link.dev_oe_n, link.stn_oe_n, link.mdc, normal_power}), 32'h0000000D);
		presetn <= 1'b1;
		wait_log(11);
		for (i = 0; i < 11; i++)
			chk(32'(log[i]), 32'(tail[i]));
		for (i = 0; i < 10; i++) begin
			frame(OP_ADDR, rows[i][0]);
			frame(OP_READ, 16'h0000);
			chk(rd, {16'h0, rows[i][1]});
		end
		log.delete();
		lane_sync <= 4'h7;
		repeat (200) @(posedge pclk);
		chk(32'(log.size()), 32'h0);
		lane_sync <= 4'hF;
		frame(OP_ADDR, REG_VCTRL);
		frame(OP_WRITE, 16'h8000);
		frame(OP_READ, 16'h0000);
		chk(rd, 32'h00008000);
		log.delete();
		lane_sync <= 4'h7;
		wait_log(4);
		for (i = 0; i < 4; i++)
			chk(32'(log[i]), 32'(tail[11 + i]));
		lane_sync <= 4'hF;
		frame(OP_ADDR, REG_CTRL1);
		log.delete();
		frame(OP_WRITE, 16'h4800);
		wait_log(2);
		chk(32'(log[0]), 32'({1'b1, CORE_LOOP_A, D_LOOP_ON}));
		chk(32'(log[1]), 32'({1'b1, CORE_LOOP_B, D_LOOP_ON}));
		chk(32'(loopback_en), 32'h00000001);
		i = rst_cnt;
		frame(OP_WRITE, 16'h8800);
		chk(rst_cnt, i + 1);
		frame(OP_ADDR, REG_CTRL1);
		frame(OP_READ, 16'h0000);
		chk(rd, 32'h00000800);
		frame(OP_ADDR, REG_IDH);
		frame(OP_READ_INC, 16'h0000);
		chk(rd, 32'h00001234);
		frame(OP_READ, 16'h0000);
		chk(rd, 32'h00005678);
		for (i = 0; i < 3; i++) begin
			frame(OP_READ, 16'h0000, (i == 0) ? 5'h00 : XS_DEVICE_TYPE, (i == 1) ? 5'h02 : 5'h01, i == 2);
			chk(rd, 32'h0000FFFF);
		end
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(err), 32'h00000001);
		chk(rd, 32'h00000000);
		apb(1'b1, STN_CMD, {9'h020, 5'h01, OP_ADDR, 16'h0000});
		repeat (100) @(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		@(posedge pclk);
		chk(32'({link.dev_oe_n, link.stn_oe_n, link.mdc}), 32'h00000006);
		presetn <= 1'b1;
		frame(OP_ADDR, REG_IDL);
		frame(OP_READ, 16'h0000);
		chk(rd, 32'h00005678);
		stop_test();
	end
endmodule
`default_nettype wire
